/* eew_slave.sv */
// top: two-wire memory target, start/stop detection, select/address/data write path
module eew_slave #(
    parameter logic [3:0] TYPE_ID     = eew_pkg::TYPE_ID_DEFAULT, // arbitrary value
    parameter int         PROG_CYCLES = eew_pkg::PROG_CYCLES
) (
    // clock and power-on reset
    input  wire logic                         clock_in,
    input  wire logic                         reset_n_in,
    // two-wire bus pins
    input  wire logic                         scl_in,
    input  wire logic                         sda_in,
    output logic                              sda_out,
    output logic                              sda_oe_out,
    // write protect pin, pulled low outside when undriven
    input  wire logic                         write_protect_input_in,
    // status
    output logic                              busy_out,
    output logic [eew_pkg::ADDR_W-1:0]        addr_out
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [1:0]  scl_sync_r, sda_sync_r, wp_sync_r;
    eew_pkg::eew_bus_t bus_r;
    eew_pkg::eew_state_t state_r, state_nxt;
    logic [3:0]  bit_cnt_r;
    logic [7:0]  shift_r;
    logic        ack_r;
    logic        acked_data_r;
    logic        addr_valid_r;
    logic        data_slot_r;
    logic [eew_pkg::ADDR_W-1:0] addr_r;
    logic [eew_pkg::ADDR_W-1:0] last_addr_r;
    logic        wrote_r;
    logic [31:0] prog_cnt_r;
    logic [eew_pkg::DATA_W-1:0] mem_r [eew_pkg::MEM_BYTES];
    logic [eew_pkg::DATA_W-1:0] page_buf_r [16];
    logic [15:0] page_vld_r;

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            wp_sync_r  <= 2'h0;
            bus_r      <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_in};
            sda_sync_r <= {sda_sync_r[0], sda_in};
            wp_sync_r  <= {wp_sync_r[0], write_protect_input_in};
            bus_r      <= '{scl: scl_sync_r[1], sda: sda_sync_r[1]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    wire scl_now    = scl_sync_r[1];
    wire sda_now    = sda_sync_r[1];
    wire wp_now     = wp_sync_r[1];
    wire busy       = (state_r == eew_pkg::EEW_PROG);
    wire start_det  = bus_r.scl && scl_now && bus_r.sda && !sda_now && !busy;
    wire stop_det   = bus_r.scl && scl_now && !bus_r.sda && sda_now && !busy;
    wire scl_rise   = !bus_r.scl && scl_now;
    wire scl_fall   = bus_r.scl && !scl_now;
    wire byte_done  = scl_rise && (bit_cnt_r == 4'h7);
    wire [7:0] byte_in = {shift_r[6:0], sda_now};
    wire sel_match  = (byte_in[7:4] == TYPE_ID) && !byte_in[0];
    wire prog_done  = busy && (prog_cnt_r == 32'h0);
    // the first rise of the slot after a data acknowledge has already counted one bit
    wire prog_go    = stop_det && (state_r == eew_pkg::EEW_DATA)
                      && (bit_cnt_r == 4'h1) && acked_data_r;
    wire [3:0] page_ofs = addr_r[eew_pkg::PAGE_W-1:0];

    // next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            eew_pkg::EEW_IDLE:   if (start_det) state_nxt = eew_pkg::EEW_SELECT;
            eew_pkg::EEW_SELECT: if (byte_done) state_nxt = sel_match ? eew_pkg::EEW_ADDR
                                                                      : eew_pkg::EEW_IDLE;
            eew_pkg::EEW_ADDR:   if (byte_done) state_nxt = eew_pkg::EEW_DATA;
            eew_pkg::EEW_DATA:   state_nxt = eew_pkg::EEW_DATA;
            eew_pkg::EEW_PROG:   if (prog_done) state_nxt = eew_pkg::EEW_IDLE;
            default:             state_nxt = eew_pkg::EEW_IDLE;
        endcase
        if (!busy && start_det)
            state_nxt = eew_pkg::EEW_SELECT;
        else if (!busy && stop_det)
            state_nxt = prog_go ? eew_pkg::EEW_PROG : eew_pkg::EEW_IDLE;
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r <= eew_pkg::EEW_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // bit counter and shift register; the ninth slot is counted as 8
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bit_cnt_r    <= eew_pkg::BIT_CNT_RESET;
            shift_r      <= 8'h00;
        end else if (start_det || busy) begin
            bit_cnt_r    <= eew_pkg::BIT_CNT_RESET;
        end else if (scl_rise) begin
            shift_r      <= byte_in;
            bit_cnt_r    <= (bit_cnt_r == eew_pkg::BIT_ACK_SLOT) ? eew_pkg::BIT_CNT_RESET
                                                                  : bit_cnt_r + 4'h1;
        end
    end

    // acknowledge drive: pull low from the falling edge after bit 8 to the next fall
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ack_r        <= 1'b0;
        end else if (busy || start_det || stop_det) begin
            ack_r        <= 1'b0;
        end else if (scl_fall && bit_cnt_r == eew_pkg::BIT_ACK_SLOT) begin
            case (state_r)
                eew_pkg::EEW_ADDR: ack_r <= 1'b1;
                eew_pkg::EEW_DATA: ack_r <= 1'b1;
                default:           ack_r <= 1'b0;
            endcase
        end else if (scl_fall && bit_cnt_r == 4'h1 && state_r == eew_pkg::EEW_DATA
                     && addr_valid_r) begin
            ack_r <= 1'b0;
        end else if (scl_fall) begin
            ack_r <= 1'b0;
        end
    end

    // which byte the pending ninth slot belongs to
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            addr_valid_r <= 1'b0;
            data_slot_r  <= 1'b0;
        end else if (start_det || busy) begin
            addr_valid_r <= 1'b0;
            data_slot_r  <= 1'b0;
        end else if (byte_done) begin
            addr_valid_r <= (state_r == eew_pkg::EEW_DATA) || (state_r == eew_pkg::EEW_ADDR);
            data_slot_r  <= (state_r == eew_pkg::EEW_DATA);
        end
    end

    // the slot acknowledge is withheld for data bytes while protected
    wire ack_drive = ack_r && !(data_slot_r && wp_now);

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sda_out    <= 1'b0;
            sda_oe_out <= 1'b0;
            busy_out   <= 1'b0;
        end else begin
            sda_out    <= 1'b0;
            sda_oe_out <= ack_drive && !busy;
            busy_out   <= (state_nxt == eew_pkg::EEW_PROG);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // address counter, page buffer; memory is only committed at the end of programming
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            addr_r       <= '0;
            last_addr_r  <= '0;
            wrote_r      <= 1'b0;
            page_vld_r   <= 16'h0000;
        end else if (prog_done) begin
            addr_r       <= last_addr_r + 11'h001;
            page_vld_r   <= 16'h0000;
            wrote_r      <= 1'b0;
        end else if (!busy && byte_done && state_r == eew_pkg::EEW_SELECT && sel_match) begin
            addr_r[10:8] <= byte_in[3:1];
            page_vld_r   <= 16'h0000;
            wrote_r      <= 1'b0;
        end else if (!busy && byte_done && state_r == eew_pkg::EEW_ADDR) begin
            addr_r[7:0]  <= byte_in;
        end else if (!busy && byte_done && state_r == eew_pkg::EEW_DATA && !wp_now) begin
            page_buf_r[page_ofs]  <= byte_in;
            page_vld_r[page_ofs]  <= 1'b1;
            last_addr_r           <= addr_r;
            wrote_r               <= 1'b1;
            addr_r[3:0]           <= page_ofs + 4'h1;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            acked_data_r <= 1'b0;
        end else if (start_det || busy) begin
            acked_data_r <= 1'b0;
        end else if (scl_rise) begin
            // set only if the line really was low in a data slot; survives the next rise, clears on the one after
            acked_data_r <= (bit_cnt_r == eew_pkg::BIT_ACK_SLOT && data_slot_r && !sda_now)
                            || (acked_data_r && bit_cnt_r == eew_pkg::BIT_CNT_RESET);
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prog_cnt_r <= '0;
        end else if (prog_go) begin
            prog_cnt_r <= PROG_CYCLES - 1;
        end else if (busy && prog_cnt_r != 32'h0) begin
            prog_cnt_r <= prog_cnt_r - 32'h1;
        end
    end

    // one process owns the array; the buffered bytes of the page land in the cycle programming ends
    always_ff @(posedge clock_in) begin
        if (prog_done) begin
            for (int i = 0; i < 16; i++) begin
                if (page_vld_r[i])
                    mem_r[{last_addr_r[10:4], i[3:0]}] <= page_buf_r[i];
            end
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) addr_out <= '0;
        else             addr_out <= addr_r;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks on the write path; one clock domain, quiet while reset is low
    default clocking dc @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);

    // the pin is only ever pulled low, never driven high
    a_sda_low_only: assert property (
        sda_out == 1'b0)
        else $error("data pin driven high");

    // the pull-down only starts from the falling edge that closes bit eight
    a_ack_slot_only: assert property (
        $rose(sda_oe_out) |-> $past(bit_cnt_r, 2) == eew_pkg::BIT_ACK_SLOT)
        else $error("acknowledge outside the ninth slot");

    // a foreign or read select sends the target back to standby
    a_mismatch_idle: assert property (
        byte_done && state_r == eew_pkg::EEW_SELECT && !sel_match |=> state_r == eew_pkg::EEW_IDLE)
        else $error("mismatched select not dropped");

    // programming needs a data byte that was really acknowledged
    a_prog_after_ack: assert property (
        $rose(busy_out) |-> $past(acked_data_r))
        else $error("programming without a data acknowledge");

    // nothing reaches the line while programming
    a_oe_off_busy: assert property (
        busy_out |-> !sda_oe_out)
        else $error("line pulled during programming");

    // the bit counter is frozen, so no start or select is decoded while busy
    a_busy_frozen: assert property (
        busy |=> bit_cnt_r == eew_pkg::BIT_CNT_RESET)
        else $error("bus decoded during programming");

    // protected data bytes are never acknowledged
    a_wp_data_nack: assert property (
        data_slot_r && wp_now |=> !sda_oe_out)
        else $error("protected data byte acknowledged");

    // the page bits stay put while bytes stream in; only the low nibble moves
    a_page_fixed: assert property (
        byte_done && state_r == eew_pkg::EEW_DATA && !wp_now |=> addr_r[10:4] == $past(addr_r[10:4]))
        else $error("page address moved during page write");

    // the end of programming frees the bus for the next poll
    a_prog_ends_idle: assert property (
        prog_done |=> state_r == eew_pkg::EEW_IDLE)
        else $error("still busy after programming");

    // main scenarios: program start, protected data, page wrap, poll while busy
    c_prog_start: cover property ($rose(busy_out));
    c_wp_withheld: cover property (ack_r && data_slot_r && wp_now);
    c_page_wrap: cover property (byte_done && state_r == eew_pkg::EEW_DATA && page_ofs == 4'hf);
    c_busy_poll: cover property (busy && bus_r.scl && scl_now && bus_r.sda && !sda_now);
endmodule // eew_slave

/* eew_pkg.sv */
// package: constants and carrier types for the two-wire memory write path
package eew_pkg;
    localparam int          ADDR_W          = 11;
    localparam int          DATA_W          = 8;
    localparam int          PAGE_W          = 4;
    localparam int          MEM_BYTES       = 2048;
    localparam int          CLK_PERIOD_NS   = 8;
    localparam int          PROG_TIME_NS    = 5000000;
    localparam int          PROG_CYCLES     = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  TYPE_ID_DEFAULT = 4'h5;
    localparam logic [3:0]  BIT_CNT_RESET   = 4'h0;
    localparam logic [3:0]  BIT_ACK_SLOT    = 4'h8;
    localparam logic [DATA_W-1:0] MEM_RESET = 8'hff;

    typedef enum {
        EEW_IDLE,
        EEW_SELECT,
        EEW_ADDR,
        EEW_DATA,
        EEW_PROG
    } eew_state_t;

    // sampled bus lines after synchronisation
    typedef struct packed {
        logic scl;
        logic sda;
    } eew_bus_t;
endpackage

/* eew_bus_master.sv */
// partner model: two-wire bus master that makes the serial clock
module eew_bus_master (
    // system clock used to pace the bus
    input  wire logic clock_in,
    // resolved data line
    input  wire logic sda_line_in,
    // bus outputs, data is open drain
    output logic      scl_out,
    output logic      sda_low_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // serial clock stands high outside frames, data released to the pull-up
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    task automatic start_cond();
        tick(2);
        sda_low_out <= 1'b1;
        tick(5);
        scl_out <= 1'b0;
    endtask
    task automatic stop_cond();
        tick(2);
        sda_low_out <= 1'b1;
        tick(3);
        scl_out <= 1'b1;
        tick(5);
        sda_low_out <= 1'b0;
        tick(5);
    endtask
    // data changes only mid low phase; 80 ns per bit
    task automatic clock_bit(input logic b);
        tick(2);
        sda_low_out <= ~b;
        tick(3);
        scl_out <= 1'b1;
        tick(5);
        scl_out <= 1'b0;
    endtask
    task automatic send_byte(input logic [7:0] v, output logic ack);
        for (int i = 7; i >= 0; i--) clock_bit(v[i]);
        tick(2);
        sda_low_out <= 1'b0;
        tick(3);
        scl_out <= 1'b1;
        tick(4);
        ack = ~sda_line_in;
        tick(1);
        scl_out <= 1'b0;
    endtask
endmodule // eew_bus_master

/* tb_top.sv */
// testbench: write path of the two-wire memory target
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PROG = 400;
    logic        clock_in = 1'b0;
    logic        reset_n  = 1'b0;
    logic        wp       = 1'b0;
    wire         scl;
    wire         m_low;
    wire         sda_oe;
    wire         sda_o;
    wire         busy;
    wire  [10:0] addr;
    // wired-and with pull-up: released line reads high
    wire         sda_line = ~(m_low | (sda_oe & ~sda_o));
    int          n_mismatch = 0;
    int          checks = 0;
    logic        a;
    eew_slave #(.TYPE_ID(eew_pkg::TYPE_ID_DEFAULT), .PROG_CYCLES(PROG)) i_eew_slave (
        .clock_in(clock_in), .reset_n_in(reset_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .write_protect_input_in(wp),
        .busy_out(busy), .addr_out(addr));
    eew_bus_master i_eew_bus_master (
        .clock_in(clock_in), .sda_line_in(sda_line), .scl_out(scl), .sda_low_out(m_low));
    initial begin
        forever #4 clock_in = ~clock_in;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string m);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %b", $time, m, got);
        end
    endtask
    task automatic chk_addr(input logic [10:0] got, input logic [10:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t address %h expected %h", $time, got, exp);
        end
    endtask
    task automatic sel(input logic [2:0] hi, input logic rd, input logic exp);
        i_eew_bus_master.send_byte({eew_pkg::TYPE_ID_DEFAULT, hi, rd}, a);
        chk_bit(a, exp, "select ack");
    endtask
    task automatic frame(input logic [2:0] hi, input logic [7:0] lo, input int n,
                         input logic exp);
        i_eew_bus_master.start_cond();
        sel(hi, 1'b0, 1'b1);
        i_eew_bus_master.send_byte(lo, a);
        chk_bit(a, 1'b1, "address ack");
        for (int i = 0; i < n; i++) begin
            i_eew_bus_master.send_byte(8'h5a + 8'(i), a);
            chk_bit(a, exp, "data ack");
        end
        i_eew_bus_master.stop_cond();
    endtask
    // first poll must land inside programming; polling repeats until one after it is acknowledged
    task automatic wait_prog(input logic [10:0] exp_addr);
        int tries;
        tries = 0;
        a = 1'b0;
        for (int i = 0; i < 40 && busy !== 1'b1; i++) @(posedge clock_in);
        chk_bit(busy, 1'b1, "busy after stop");
        chk_bit(sda_oe, 1'b0, "line released");
        while (a !== 1'b1 && tries < 20) begin
            tries++;
            i_eew_bus_master.start_cond();
            i_eew_bus_master.send_byte({eew_pkg::TYPE_ID_DEFAULT, exp_addr[10:8], 1'b0}, a);
            i_eew_bus_master.stop_cond();
        end
        if (a !== 1'b1) begin
            n_mismatch++;
            $display("[ERR] %0t polling never acknowledged", $time);
        end
        chk_bit(tries > 1, 1'b1, "busy poll refused");
        chk_addr(addr, exp_addr);
        chk_bit(busy, 1'b0, "no program after select stop");
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic s_byte_write();
        frame(3'h2, 8'h37, 1, 1'b1);
        wait_prog(11'h238);
    endtask
    task automatic s_page_wrap();
        frame(3'h7, 8'hfe, 3, 1'b1);
        wait_prog(11'h7f1);
    endtask
    task automatic s_protect();
        wp <= 1'b1;
        frame(3'h1, 8'h10, 2, 1'b0);
        wp <= 1'b0;
        i_eew_bus_master.tick(30);
        chk_bit(busy, 1'b0, "protected frame programmed");
    endtask
    task automatic s_refused();
        i_eew_bus_master.start_cond();
        i_eew_bus_master.send_byte(8'h6e, a);
        chk_bit(a, 1'b0, "foreign select");
        i_eew_bus_master.stop_cond();
        i_eew_bus_master.start_cond();
        sel(3'h0, 1'b1, 1'b0);
        i_eew_bus_master.stop_cond();
        i_eew_bus_master.start_cond();
        sel(3'h3, 1'b0, 1'b1);
        i_eew_bus_master.send_byte(8'h44, a);
        i_eew_bus_master.stop_cond();
        i_eew_bus_master.tick(30);
        chk_bit(busy, 1'b0, "stop after address");
        chk_bit(sda_o, 1'b0, "data pin level");
    endtask
    initial begin
        repeat (3) @(posedge clock_in);
        chk_bit(sda_oe | busy, 1'b0, "quiet in reset");
        reset_n <= 1'b1;
        repeat (4) @(posedge clock_in);
        s_byte_write();
        s_page_wrap();
        s_protect();
        s_refused();
        tally_and_finish();
    end
endmodule // tb_top
